//--- bench/dem_hub_model.sv
// =========================================
// hub side: accepts special message cycles
module dem_hub_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic msg_valid_i,
   input wire logic [1:0] msg_kind_i,
   input wire logic [3:0] delay_i,
   output logic msg_ack_o,
   output logic [7:0] ctrl_cnt_o,
   output logic [7:0] mgmt_cnt_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] wait_r = 4'h0;
   logic ack_r = 1'b0;
   logic [7:0] ctrl_r = 8'h00;
   logic [7:0] mgmt_r = 8'h00;

   assign msg_ack_o = ack_r;
   assign ctrl_cnt_o = ctrl_r;
   assign mgmt_cnt_o = mgmt_r;

   // =========================================
   // acceptance, prompt or after delay_i cycles
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         wait_r <= 4'h0;
      end else if (msg_valid_i && ack_r) begin
         ack_r <= 1'b0;
         wait_r <= 4'h0;
      end else if (msg_valid_i) begin
         if (wait_r >= delay_i) begin
            ack_r <= 1'b1;
         end else begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end

   // =========================================
   // tally of received messages by kind
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_r <= 8'h00;
         mgmt_r <= 8'h00;
      end else if (msg_valid_i && ack_r) begin
         if (msg_kind_i == 2'b01) begin
            ctrl_r <= ctrl_r + 8'h01;
         end
         if (msg_kind_i == 2'b10) begin
            mgmt_r <= mgmt_r + 8'h01;
         end
      end
   end
endmodule

//--- bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic por_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic [7:0] err_a_i = 8'h00;
   logic [7:0] err_b_i = 8'h00;
   logic [3:0] hub_delay = 4'h0;
   logic [15:0] rdata_o;
   logic msg_valid_o;
   logic [1:0] msg_kind_o;
   logic msg_ack_i;
   logic err_any_o;
   logic [7:0] ctrl_cnt;
   logic [7:0] mgmt_cnt;
   logic [15:0] exp_c;
   logic [15:0] exp_m;
   logic [7:0] en;
   logic [7:0] ra;
   logic [7:0] regs [3] = '{8'h84, 8'h88, 8'h8a};
   int fail_count = 0;
   int samples_checked = 0;

   always #5 clk_i = ~clk_i;

   dem_top dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .err_a_i(err_a_i),
      .err_b_i(err_b_i), .msg_valid_o(msg_valid_o), .msg_kind_o(msg_kind_o),
      .msg_ack_i(msg_ack_i), .err_any_o(err_any_o));

   dem_hub_model hub (.clk_i(clk_i), .rst_i(rst_i), .msg_valid_i(msg_valid_o),
      .msg_kind_i(msg_kind_o), .delay_i(hub_delay), .msg_ack_o(msg_ack_i),
      .ctrl_cnt_o(ctrl_cnt), .mgmt_cnt_o(mgmt_cnt));

   // =========================================
   // access tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      check(rdata_o, exp);
   endtask

   task automatic pulse(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_i);
      err_a_i <= a;
      err_b_i <= b;
      @(posedge clk_i);
      err_a_i <= 8'h00;
      err_b_i <= 8'h00;
   endtask

   task automatic print_verdict;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // =========================================
   // watchdog
   initial begin
      #200000;
      fail_count++;
      print_verdict();
   end

   // =========================================
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      rdchk(8'h82, 16'h0000);
      rdchk(8'h90, 16'h0000);
      foreach (regs[i]) begin
         rdchk(regs[i], 16'h0000);
         wr(regs[i], 16'hffa5);
         rdchk(regs[i], 16'h00a5);
         wr(regs[i], 16'h0000);
      end
      // first event lands in the first word, later ones in the next word
      pulse(8'h01, 8'h00);
      rdchk(8'h80, 16'h0001);
      pulse(8'h00, 8'h02);
      rdchk(8'h82, 16'h0200);
      pulse(8'h80, 8'h00);
      rdchk(8'h82, 16'h0280);
      check({15'h0000, err_any_o}, 16'h0001);
      wr(8'h82, 16'h0200);
      rdchk(8'h82, 16'h0080);
      wr(8'h82, 16'h0000);
      rdchk(8'h82, 16'h0080);
      wr(8'h80, 16'hffff);
      wr(8'h82, 16'hffff);
      rdchk(8'h82, 16'h0000);
      check({15'h0000, err_any_o}, 16'h0000);
      // masked class on both channels, control routing armed
      wr(8'h88, 16'h0002);
      wr(8'h84, 16'h0002);
      pulse(8'h02, 8'h02);
      rdchk(8'h80, 16'h0000);
      rdchk(8'h82, 16'h0000);
      repeat (6) @(posedge clk_i);
      check({8'h00, ctrl_cnt}, 16'h0000);
      wr(8'h84, 16'h0000);
      pulse(8'h00, 8'h02);
      repeat (8) @(posedge clk_i);
      check({8'h00, ctrl_cnt}, 16'h0001);
      rdchk(8'h80, 16'h0200);
      wr(8'h80, 16'hffff);
      wr(8'h88, 16'h0000);
      exp_c = 16'h0001;
      exp_m = 16'h0000;
      // every class through each route, alternating channels
      for (int k = 0; k < 16; k++) begin
         en = 8'h01 << (k % 8);
         ra = (k < 8) ? 8'h88 : 8'h8a;
         hub_delay <= (k < 8) ? 4'h0 : 4'h3;
         wr(ra, {8'h00, en});
         repeat (2) begin
            if (k % 2 == 1) pulse(8'h00, en);
            else pulse(en, 8'h00);
         end
         repeat (12) @(posedge clk_i);
         if (k < 8) exp_c = exp_c + 16'h0001;
         else exp_m = exp_m + 16'h0001;
         check({8'h00, ctrl_cnt}, exp_c);
         check({8'h00, mgmt_cnt}, exp_m);
         wr(8'h80, 16'hffff);
         wr(8'h82, 16'hffff);
         wr(ra, 16'h0000);
      end
      // warm reset keeps flags and mask, power-on clears them
      wr(8'h84, 16'h0040);
      wr(8'h88, 16'h0011);
      pulse(8'h01, 8'h00);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(8'h84, 16'h0040);
      rdchk(8'h80, 16'h0001);
      rdchk(8'h88, 16'h0000);
      pulse(8'h00, 8'h40);
      rdchk(8'h82, 16'h0000);
      @(posedge clk_i);
      rst_i <= 1'b1;
      por_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      rdchk(8'h84, 16'h0000);
      rdchk(8'h80, 16'h0000);
      print_verdict();
   end
endmodule

//--- core/dem_msg_gen.sv
module dem_msg_gen #(
   parameter int NCLS = dem_pkg::NCLS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   dem_msg_if.gen bus
);
   logic [NCLS-1:0] folded;
   logic hit;
   logic hit_r;
   logic pending_r;

   // elaboration check: fold below assumes two 8-class halves
   if (NCLS != dem_pkg::NCLS) begin : g_bad_ncls
      $error("class count must match the status word halves");
   end

   // ===========================================
   // fold both channels of both words per class
   always_comb begin
      folded = bus.first_err[15:8] | bus.first_err[7:0]
             | bus.next_err[15:8] | bus.next_err[7:0]; // [RULE8] [RULE9] [RULE13]
      hit = |(folded & bus.enable); // [RULE17]
   end

   // ===========================================
   // rising edge makes one request
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= hit;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pending_r <= 1'b0;
      end else if (hit && !hit_r) begin
         pending_r <= 1'b1; // [RULE20]
      end else if (bus.take) begin
         pending_r <= 1'b0;
      end
   end

   assign bus.pending = pending_r;

   rise_pend_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE20]
      (hit && !hit_r) |=> pending_r)
      else $error("edge of enabled flags made no request");

   no_cause_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
      $rose(pending_r) |-> $past(hit))
      else $error("request without an enabled flag");
endmodule

//--- core/dem_top.sv
// The strobed register port was left to the implementer.
module dem_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic [7:0] err_a_i,
   input wire logic [7:0] err_b_i,
   output logic msg_valid_o,
   output logic [1:0] msg_kind_o,
   input wire logic msg_ack_i,
   output logic err_any_o
);
   logic [15:0] first_err_r;
   logic [15:0] next_err_r;
   logic [7:0] mask_r;
   logic [7:0] ctrl_en_r;
   logic [7:0] mgmt_en_r;
   logic [15:0] rdata_r;
   logic msg_valid_r;
   dem_pkg::dem_kind_t msg_kind_r;
   dem_pkg::dem_state_t state_r;
   logic err_any_r;

   logic [15:0] ev;
   logic [15:0] first_set;
   logic [15:0] next_set;
   logic [15:0] first_clr;
   logic [15:0] next_clr;
   logic wr_first;
   logic wr_next;
   logic wr_mask;
   logic wr_ctrl;
   logic wr_mgmt;
   logic take_ctrl;
   logic take_mgmt;

   dem_msg_if ctrl_bus ();
   dem_msg_if mgmt_bus ();

   // ===========================================
   // register decode
   always_comb begin
      wr_first = wr_i && (addr_i == dem_pkg::ADDR_FIRST);
      wr_next = wr_i && (addr_i == dem_pkg::ADDR_NEXT);
      wr_mask = wr_i && (addr_i == dem_pkg::ADDR_MASK);
      wr_ctrl = wr_i && (addr_i == dem_pkg::ADDR_CTRL);
      wr_mgmt = wr_i && (addr_i == dem_pkg::ADDR_MGMT);
   end

   // ===========================================
   // event qualification
   always_comb begin
      // one mask bit gates both channels
      ev = {err_b_i & ~mask_r, err_a_i & ~mask_r}; // [RULE3] [RULE4] [RULE7] [RULE19]
      if (first_err_r == dem_pkg::STATUS_RST) begin
         first_set = ev;
         next_set = '0;
      end else begin
         first_set = '0;
         next_set = ev; // [RULE2]
      end
      first_clr = wr_first ? wdata_i : '0;
      next_clr = wr_next ? wdata_i : '0; // [RULE18]
   end

   // ===========================================
   // sticky status words, reset only at power-on; software clears bits by writing ones
   always_ff @(posedge clk_i or posedge por_i) begin
      if (por_i) begin
         first_err_r <= dem_pkg::STATUS_RST;
      end else begin
         first_err_r <= (first_err_r & ~first_clr) | first_set; // [RULE18]
      end
   end

   always_ff @(posedge clk_i or posedge por_i) begin
      if (por_i) begin
         next_err_r <= dem_pkg::STATUS_RST; // [RULE1]
      end else begin
         // set wins over a same-cycle clear
         next_err_r <= (next_err_r & ~next_clr) | next_set; // [RULE1] [RULE18]
      end
   end

   // ===========================================
   // mask survives warm reset
   always_ff @(posedge clk_i or posedge por_i) begin
      if (por_i) begin
         mask_r <= dem_pkg::REG8_RST; // [RULE5]
      end else if (wr_mask) begin
         mask_r <= wdata_i[7:0]; // [RULE6] [RULE16]
      end
   end

   // ===========================================
   // message routing enables
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_en_r <= dem_pkg::REG8_RST; // [RULE16]
      end else if (wr_ctrl) begin
         ctrl_en_r <= wdata_i[7:0]; // [RULE14]
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mgmt_en_r <= dem_pkg::REG8_RST; // [RULE16]
      end else if (wr_mgmt) begin
         mgmt_en_r <= wdata_i[7:0]; // [RULE15]
      end
   end

   // ===========================================
   // read port, data one cycle after strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= '0;
      end else if (rd_i) begin
         case (addr_i)
            dem_pkg::ADDR_FIRST: begin
               rdata_r <= first_err_r;
            end
            dem_pkg::ADDR_NEXT: begin
               rdata_r <= next_err_r;
            end
            dem_pkg::ADDR_MASK: begin
               rdata_r <= {8'h00, mask_r};
            end
            dem_pkg::ADDR_CTRL: begin
               rdata_r <= {8'h00, ctrl_en_r};
            end
            dem_pkg::ADDR_MGMT: begin
               rdata_r <= {8'h00, mgmt_en_r};
            end
            default: begin
               rdata_r <= '0;
            end
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   // ===========================================
   // request generators, one per message type
   assign ctrl_bus.first_err = first_err_r;
   assign ctrl_bus.next_err = next_err_r;
   assign ctrl_bus.enable = ctrl_en_r; // [RULE8]
   assign ctrl_bus.take = take_ctrl;
   assign mgmt_bus.first_err = first_err_r;
   assign mgmt_bus.next_err = next_err_r;
   assign mgmt_bus.enable = mgmt_en_r; // [RULE9]
   assign mgmt_bus.take = take_mgmt;

   dem_msg_gen #(
      .NCLS(dem_pkg::NCLS)
   ) u_ctrl_gen (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(ctrl_bus)
   );

   dem_msg_gen #(
      .NCLS(dem_pkg::NCLS)
   ) u_mgmt_gen (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bus(mgmt_bus)
   );

   // ===========================================
   // special message cycle sender
   always_comb begin
      take_ctrl = (state_r == dem_pkg::ST_SEND) && msg_ack_i
                  && (msg_kind_r == dem_pkg::MSG_CTRL);
      take_mgmt = (state_r == dem_pkg::ST_SEND) && msg_ack_i
                  && (msg_kind_r == dem_pkg::MSG_MGMT);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= dem_pkg::ST_IDLE;
         msg_valid_r <= 1'b0;
         msg_kind_r <= dem_pkg::MSG_NONE;
      end else begin
         case (state_r)
            dem_pkg::ST_IDLE: begin
               // both can be pending at once; the control request goes first
               if (ctrl_bus.pending) begin // [RULE12]
                  state_r <= dem_pkg::ST_SEND;
                  msg_valid_r <= 1'b1;
                  msg_kind_r <= dem_pkg::MSG_CTRL; // [RULE10]
               end else if (mgmt_bus.pending) begin
                  state_r <= dem_pkg::ST_SEND;
                  msg_valid_r <= 1'b1;
                  msg_kind_r <= dem_pkg::MSG_MGMT; // [RULE11]
               end
            end
            dem_pkg::ST_SEND: begin
               if (msg_ack_i) begin
                  state_r <= dem_pkg::ST_IDLE;
                  msg_valid_r <= 1'b0;
                  msg_kind_r <= dem_pkg::MSG_NONE;
               end
            end
            default: begin
               state_r <= dem_pkg::ST_IDLE;
               msg_valid_r <= 1'b0;
               msg_kind_r <= dem_pkg::MSG_NONE;
            end
         endcase
      end
   end

   // ===========================================
   // global logging level
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         err_any_r <= 1'b0;
      end else begin
         err_any_r <= |(first_err_r | next_err_r); // [RULE3]
      end
   end

   assign rdata_o = rdata_r;
   assign msg_valid_o = msg_valid_r;
   assign msg_kind_o = msg_kind_r;
   assign err_any_o = err_any_r;

   // ===========================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || por_i);

   sequence ctrl_ready_s;
      (state_r == dem_pkg::ST_IDLE) && ctrl_bus.pending;
   endsequence

   sequence ctrl_sent_s;
      msg_valid_o && (msg_kind_o == dem_pkg::MSG_CTRL);
   endsequence

   sequence mgmt_ready_s;
      (state_r == dem_pkg::ST_IDLE) && !ctrl_bus.pending && mgmt_bus.pending;
   endsequence

   sequence mgmt_sent_s;
      msg_valid_o && (msg_kind_o == dem_pkg::MSG_MGMT);
   endsequence

   mask_gate_a: assert property ( // [RULE3]
      ##1 (((next_err_r | first_err_r) & ~$past(next_err_r | first_err_r))
      & {$past(mask_r), $past(mask_r)}) == 16'h0000)
      else $error("masked class was logged");

   next_log_a: assert property ( // [RULE2]
      (first_err_r != 16'h0000 && ev != 16'h0000)
      |=> ((next_err_r & $past(ev)) == $past(ev)))
      else $error("event missing from next-error word");

   first_log_a: assert property ( // [RULE19]
      (first_err_r == 16'h0000 && ev != 16'h0000)
      |=> (first_err_r == $past(ev))
      && (next_err_r == ($past(next_err_r) & ~$past(next_clr))))
      else $error("first event not captured in first-error word");

   w1c_clear_a: assert property ( // [RULE18]
      (wr_next && ev == 16'h0000 && first_err_r != 16'h0000)
      |=> (next_err_r == ($past(next_err_r) & ~$past(wdata_i))))
      else $error("next-error word not cleared by write of ones");

   mask_read_a: assert property ( // [RULE16]
      (rd_i && addr_i == dem_pkg::ADDR_MASK)
      |=> (rdata_o == {8'h00, $past(mask_r)}))
      else $error("mask read data wrong");

   read_once_a: assert property ( // [RULE16]
      !rd_i |=> (rdata_o == 16'h0000))
      else $error("read data present without a read");

   ctrl_send_a: assert property ( // [RULE10]
      ctrl_ready_s |=> ctrl_sent_s)
      else $error("control message not started");

   mgmt_send_a: assert property ( // [RULE11]
      mgmt_ready_s |=> mgmt_sent_s)
      else $error("management message not started");

   msg_hold_a: assert property ( // [RULE10]
      (msg_valid_o && !msg_ack_i) |=> msg_valid_o && $stable(msg_kind_o))
      else $error("message dropped before acknowledge");

   ctrl_route_a: assert property ( // [RULE8]
      ($rose(|(ctrl_en_r & (first_err_r[15:8] | first_err_r[7:0]
      | next_err_r[15:8] | next_err_r[7:0]))) && !take_ctrl)
      |=> ctrl_bus.pending)
      else $error("enabled flag raised no control request");

   any_level_a: assert property ( // [RULE1]
      ##1 (err_any_o == ($past(rst_i) ? 1'b0
      : |($past(first_err_r) | $past(next_err_r)))))
      else $error("global error level wrong");
endmodule

//--- shared/dem_msg_if.sv
// one message type: status words and enables in, request pending out
interface dem_msg_if;
   logic [15:0] first_err;
   logic [15:0] next_err;
   logic [7:0] enable;
   logic take;
   logic pending;

   modport gen (
      input first_err,
      input next_err,
      input enable,
      input take,
      output pending
   );
   modport core (
      output first_err,
      output next_err,
      output enable,
      output take,
      input pending
   );
endinterface

//--- shared/dem_pkg.sv
// How it works
// [RULE1] 16-bit next-error word, zero at power-on, bits cleared by software.
// [RULE2] next-error word logs errors at the same bit positions as first-error.
// [RULE3] a masked class is neither logged nor signalled by any message.
// [RULE4] one mask bit covers its class on channel A and channel B.
// [RULE5] the 8-bit mask keeps its value through reset; power loss zeroes it.
// [RULE6] mask bits 7..0: test, poison, retry, copy, threshold, scrub, ue, ce.
// [RULE7] mask bit 1 blocks logging and signalling; 0 lets the event through.
// [RULE8] control enable bit n fires on status bit n or n+8 of either word.
// [RULE9] management enable bit n fires on status bit n or n+8 of either word.
// [RULE10] a control message leaves as a special message cycle to the hub.
// [RULE11] a management message leaves as a special message cycle to the hub.
// [RULE12] software enables only one message type per class.
// [RULE13] each enable bit covers channel A and channel B alike.
// [RULE14] control enable bits follow the mask order; 1 enables.
// [RULE15] management enable bits follow the mask order; 1 enables.
// [RULE16] mask and both enable registers are 8-bit, read/write, zero default.
// [RULE17] only a latched status flag with its enable bit triggers a message.
// [RULE18] writing 1 clears a flag, 0 keeps it; flags survive reset.
// [RULE19] status bits 15..8 are channel B in the same order as 7..0.
// [RULE20] one message per rising edge of the OR of enabled flags.
package dem_pkg;
   localparam int NCLS = 8;
   localparam int STW = 16;
   localparam int AW = 8;

   // register offsets
   localparam logic [7:0] ADDR_FIRST = 8'h80;
   localparam logic [7:0] ADDR_NEXT = 8'h82;
   localparam logic [7:0] ADDR_MASK = 8'h84;
   localparam logic [7:0] ADDR_CTRL = 8'h88;
   localparam logic [7:0] ADDR_MGMT = 8'h8a;

   // reset values
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [7:0] REG8_RST = 8'h00;

   // class positions, channel A; channel B adds CHB_BASE
   localparam int CLS_CE_READ = 0;
   localparam int CLS_UE_READ = 1;
   localparam int CLS_SCRUB = 2;
   localparam int CLS_THRESH = 3;
   localparam int CLS_COPY = 4;
   localparam int CLS_DBL_RETRY = 5;
   localparam int CLS_POISON = 6;
   localparam int CLS_TEST = 7;
   localparam int CHB_BASE = 8;

   typedef enum logic [1:0] {
      MSG_NONE = 2'b00,
      MSG_CTRL = 2'b01,
      MSG_MGMT = 2'b10
   } dem_kind_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } dem_state_t;
endpackage
